// [design/gcsd_top.sv]
// Control sub-command decoder of the gauge: takes the two-byte sub-command written
// to the control command pair, runs the function and returns data at the pair.
// Assumes the serial engine delivers byte writes and reads on this clock.
//
// Notes on behaviour
// - Control pair write carries sub-command to decode
// - Code 0000 returns status word, sealed or not, unless checksum lands that cycle
// - High byte: FULL_ACCESS_SEALED_FLAG,SS,CAL,CCA,BCA,CHECKSUM_VALID_FLAG flags
// - Low byte: deep,sleep,power,rup,volt,capacity
// - Identity and version codes returned at pair
// - Reset count returned, refused when sealed
// - Returns previous code, always below 0020
// - Board calibration holds its busy flag
// - Counter calibrate holds flag; store saves
// - Code 0010 arms deep sleep flag
// - Deep sleep stops link oscillator, drops
// - First two-wire message stretched 6-8 ms
// - Any traffic in deep sleep returns sleep
// - Checksum sums chemistry data, masks top
// - Top bit clear on match, set otherwise
// - Code 0020 seals the device
// - Algorithm start sets update bit, flags
// - Voltage flag drops on misfit; capacity sticky
// - Code 0041 full reset when unsealed
// - Sealed: only query and checksum codes
// - Code 0018 returns measured current
// - Calibration toggle, enter, leave; flag tracks
// - Offset reported only in calibration mode
// - Two byte transfers per command word
`timescale 1ns/10ps
`default_nettype none
`include "gcsd_cfg.svh"

module gcsd_top #(
    parameter int          STRETCH_CYC = `GCSD_STRETCH_CYC,
    parameter logic [15:0] DEV_TYPE    = 16'h0A5A, // Arbitrary identity value
    parameter logic [15:0] FW_REV      = 16'h0100,
    parameter logic [15:0] HW_REV      = 16'h0001,
    parameter logic [15:0] CHEMISTRY_IDENTIFIER_QUERY     = 16'h0010,
    parameter logic [15:0] FLASH_REV   = 16'h0001,
    parameter logic [14:0] CHEM_REF    = 15'h0000
) (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rstn_i,
    // Byte access to the control command pair
    input  wire logic                wr_i,
    input  wire logic [7:0]          addr_i,
    input  wire logic [7:0]          wdata_i,
    output logic [15:0]              ctrl_pair_o,
    // Link activity and power
    input  wire logic                link_act_i,
    input  wire logic                link_is_i2c_i,
    output logic                     osc_run_o,
    output logic                     stretch_o,
    output logic                     drop_msg_o,
    // Measurement side
    input  wire gcsd_pkg::gcsd_meas_t meas_i,
    output logic                     full_reset_o,
    output logic [15:0]              counter_offset_calibrate_o,
    output logic [15:0]              board_offset_o,
    output logic [7:0]               algo_state_o
);
    import gcsd_pkg::*;

    typedef struct packed {
        logic [7:0]   lo_byte;
        gcsd_cmd_t    cmd;
        logic [15:0]  pair;
        logic [15:0]  last_sc;
        logic [15:0]  reset_cnt;
        logic         sealed;
        logic         cal_mode;
        gcsd_cal_st_t cal_st;
        logic [15:0]  cc_tmp;
        logic [15:0]  cc_off;
        logic [15:0]  brd_off;
        logic         checksum_valid_flag;
        logic         deep_arm;
        logic         sleep;
        logic         deep;
        logic         voltage_fit_flag;
        logic         capacity_update_on_flag;
        logic [7:0]   algo;
        logic         full_reset;
        logic         chk_wait;
        logic         stretch;
        logic         drop;
        logic [31:0]  st_cnt;
    } gcsd_state_t;

    gcsd_state_t s_r;
    gcsd_state_t s_nxt;
    logic        act_m;
    logic        act_s;
    logic        act_d;
    logic        chk_start;
    logic        chk_done;
    logic [15:0] chk_res;
    logic [15:0] status_w;
    logic        allowed;

    // ======================================================================
    // Link activity synchroniser; first stage read only by second
    // ======================================================================
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            act_m <= 1'b0;
            act_s <= 1'b0;
            act_d <= 1'b0;
        end else begin
            act_m <= link_act_i;
            act_s <= act_m;
            act_d <= act_s;
        end
    end

    // ======================================================================
    // Status word assembly
    // ======================================================================
    always_comb begin
        status_w                   = 16'h0000;
        status_w[`GCSD_ST_FAS]    = s_r.sealed;
        status_w[`GCSD_ST_SS]     = s_r.sealed;
        status_w[`GCSD_ST_CAL]    = s_r.cal_mode;
        status_w[`GCSD_ST_CCA]    = (s_r.cal_st == GCSD_CAL_CC);
        status_w[`GCSD_ST_BCA]    = (s_r.cal_st == GCSD_CAL_BOARD);
        status_w[`GCSD_ST_CSV]    = s_r.checksum_valid_flag;
        status_w[`GCSD_ST_DEEP]   = s_r.deep_arm;
        status_w[`GCSD_ST_SLEEP]  = s_r.sleep;
        status_w[`GCSD_ST_CPWR]   = meas_i.const_pwr;
        status_w[`GCSD_ST_RUPOFF] = meas_i.rup_off;
        status_w[`GCSD_ST_VOK]    = s_r.voltage_fit_flag;
        status_w[`GCSD_ST_QEN]    = s_r.capacity_update_on_flag;
    end

    // Sealed state admits only the query set and the checksum code
    always_comb begin
        unique case (s_r.cmd.code)
            `GCSD_SC_STATUS, `GCSD_SC_DEV_TYPE, `GCSD_SC_FW_REV, `GCSD_SC_HW_REV,
            `GCSD_SC_CHEMISTRY_IDENTIFIER_QUERY, `GCSD_SC_FLASH_REV, `GCSD_SC_CHEM_CHK,
            `GCSD_SC_CURRENT: allowed = 1'b1;
            default:          allowed = !s_r.sealed;
        endcase
    end

    assign chk_start = s_r.cmd.valid && allowed && !s_r.chk_wait && (s_r.cmd.code == `GCSD_SC_CHEM_CHK);

    // ======================================================================
    // Decode and execute
    // ======================================================================
    always_comb begin
        s_nxt            = s_r;
        s_nxt.cmd.valid  = 1'b0;
        s_nxt.full_reset = 1'b0;
        s_nxt.drop       = 1'b0;
        // Byte writes: low then high forms the word
        if (wr_i && addr_i == `GCSD_CMD_CTRL_LO) begin
            s_nxt.lo_byte = wdata_i;
        end else if (wr_i && addr_i == `GCSD_CMD_CTRL_HI) begin
            s_nxt.cmd.valid = 1'b1;
            s_nxt.cmd.code  = {wdata_i, s_r.lo_byte};
        end
        // Calibration ends on measurement done; a new start in that cycle wins
        if (s_r.cal_st != GCSD_CAL_IDLE && meas_i.meas_done) begin
            if (s_r.cal_st == GCSD_CAL_BOARD) begin
                s_nxt.brd_off = meas_i.offset_meas;
            end else begin
                s_nxt.cc_tmp = meas_i.offset_meas;
            end
            s_nxt.cal_st = GCSD_CAL_IDLE;
        end
        if (s_r.cmd.valid && allowed) begin
            if (s_r.cmd.code < `GCSD_LAST_SC_LIMIT) begin
                s_nxt.last_sc = s_r.cmd.code;
            end
            unique case (s_r.cmd.code)
                `GCSD_SC_STATUS:    s_nxt.pair = status_w;
                `GCSD_SC_DEV_TYPE:  s_nxt.pair = DEV_TYPE;
                `GCSD_SC_FW_REV:    s_nxt.pair = FW_REV;
                `GCSD_SC_HW_REV:    s_nxt.pair = HW_REV;
                `GCSD_SC_CHEMISTRY_IDENTIFIER_QUERY:   s_nxt.pair = CHEMISTRY_IDENTIFIER_QUERY;
                `GCSD_SC_FLASH_REV: s_nxt.pair = FLASH_REV;
                `GCSD_SC_RESET_CNT: s_nxt.pair = s_r.reset_cnt;
                `GCSD_SC_LAST_SC:   s_nxt.pair = s_r.last_sc;
                `GCSD_SC_CURRENT:   s_nxt.pair = meas_i.current;
                `GCSD_SC_BOARD_CAL: s_nxt.cal_st = GCSD_CAL_BOARD;
                `GCSD_SC_CC_CAL:    s_nxt.cal_st = GCSD_CAL_CC;
                `GCSD_SC_CC_STORE:  s_nxt.cc_off = s_r.cc_tmp;
                `GCSD_SC_ARM_DEEP:  s_nxt.deep_arm = 1'b1;
                `GCSD_SC_CHEM_CHK:  s_nxt.chk_wait = 1'b1;
                `GCSD_SC_SEAL:      s_nxt.sealed = 1'b1;
                `GCSD_SC_ALGO_START: begin
                    s_nxt.algo[`GCSD_ALGO_BIT] = 1'b1;
                    s_nxt.voltage_fit_flag = 1'b1;
                    s_nxt.capacity_update_on_flag = 1'b1;
                end
                `GCSD_SC_CAL_TOGGLE: s_nxt.cal_mode = !s_r.cal_mode;
                `GCSD_SC_CAL_ENTER:  s_nxt.cal_mode = 1'b1;
                `GCSD_SC_CAL_EXIT:   s_nxt.cal_mode = 1'b0;
                `GCSD_SC_CAL_OFFSET: if (s_r.cal_mode) begin
                    s_nxt.pair = s_r.cc_off;
                end
                `GCSD_SC_FULL_RESET: begin
                    s_nxt.full_reset = 1'b1;
                    s_nxt.reset_cnt  = s_r.reset_cnt + 16'h0001;
                end
                default: ;
            endcase
        end
        // Checksum result lands at the pair
        if (chk_done) begin
            s_nxt.pair     = chk_res;
            s_nxt.checksum_valid_flag      = !chk_res[`GCSD_CHK_MSB];
            s_nxt.chk_wait = 1'b0;
        end
        // Voltage fit flag drops when unsuitable; capacity flag is sticky
        if (s_r.voltage_fit_flag && !meas_i.volt_fit) begin
            s_nxt.voltage_fit_flag = 1'b0;
        end
        // Power states
        s_nxt.sleep = meas_i.sleep_det || (s_r.sleep && !act_s);
        if (meas_i.sleep_det && s_r.deep_arm) begin
            s_nxt.deep = 1'b1;
        end
        // Wake on first traffic; stretch or drop that message
        if (s_r.deep && act_s && !act_d) begin
            s_nxt.deep     = 1'b0;
            s_nxt.deep_arm = 1'b0;
            s_nxt.sleep    = 1'b1;
            s_nxt.drop     = !link_is_i2c_i;
            s_nxt.stretch  = link_is_i2c_i;
            s_nxt.st_cnt   = 32'(STRETCH_CYC);
        end else if (s_r.stretch) begin
            if (s_r.st_cnt <= 32'd1) begin
                s_nxt.stretch = 1'b0;
            end
            s_nxt.st_cnt = s_r.st_cnt - 32'd1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_r        <= '0;
            s_r.cal_st <= GCSD_CAL_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ======================================================================
    // Checksum engine
    // ======================================================================
    gcsd_chem_sum #(
        .N_WORDS (8),
        .SEED    (16'h1234)
    ) u_chem_sum (
        .clk_i    (clk_i),
        .rstn_i   (rstn_i),
        .start_i  (chk_start),
        .ref_i    (CHEM_REF),
        .done_o   (chk_done),
        .result_o (chk_res)
    );

    // Outputs straight from state flops
    assign ctrl_pair_o    = s_r.pair;
    assign osc_run_o      = !s_r.deep;
    assign stretch_o      = s_r.stretch;
    assign drop_msg_o     = s_r.drop;
    assign full_reset_o   = s_r.full_reset;
    assign counter_offset_calibrate_o    = s_r.cc_off;
    assign board_offset_o = s_r.brd_off;
    assign algo_state_o   = s_r.algo;

    // ======================================================================
    // Checks
    // ======================================================================
    sequence s_seal_cmd;
        s_r.cmd.valid && s_r.cmd.code == `GCSD_SC_SEAL;
    endsequence

    property p_seal;
        @(posedge clk_i) disable iff (!rstn_i)
        s_seal_cmd |=> ctrl_pair_o == $past(ctrl_pair_o) ##0 s_r.sealed;
    endproperty
    a_seal: assert property (p_seal) else $error("seal not taken");

    property p_status;
        @(posedge clk_i) disable iff (!rstn_i)
        (s_r.cmd.valid && s_r.cmd.code == `GCSD_SC_STATUS && !chk_done)
            |=> ctrl_pair_o[`GCSD_ST_SS] == $past(s_r.sealed);
    endproperty
    a_status: assert property (p_status) else $error("status word wrong");

    property p_sealed_refuse;
        @(posedge clk_i) disable iff (!rstn_i)
        (s_r.sealed && s_r.cmd.valid && s_r.cmd.code == `GCSD_SC_RESET_CNT && !chk_done)
            |=> $stable(ctrl_pair_o);
    endproperty
    a_sealed_refuse: assert property (p_sealed_refuse) else $error("sealed code ran");

    property p_last_limit;
        @(posedge clk_i) disable iff (!rstn_i)
        s_r.last_sc < `GCSD_LAST_SC_LIMIT;
    endproperty
    a_last_limit: assert property (p_last_limit) else $error("last code over limit");

    property p_qen_sticky;
        @(posedge clk_i) disable iff (!rstn_i)
        s_r.capacity_update_on_flag |=> s_r.capacity_update_on_flag;
    endproperty
    a_qen_sticky: assert property (p_qen_sticky) else $error("capacity flag cleared");

    property p_wake;
        @(posedge clk_i) disable iff (!rstn_i)
        (s_r.deep && act_s && !act_d) |=> !s_r.deep && s_r.sleep && !s_r.deep_arm;
    endproperty
    a_wake: assert property (p_wake) else $error("wake wrong");

    property p_stretch_len;
        @(posedge clk_i) disable iff (!rstn_i)
        $rose(stretch_o) |-> stretch_o [*8];
    endproperty
    a_stretch_len: assert property (p_stretch_len) else $error("stretch too short");

    property p_fullreset;
        @(posedge clk_i) disable iff (!rstn_i)
        full_reset_o |-> !$past(s_r.sealed);
    endproperty
    a_fullreset: assert property (p_fullreset) else $error("reset while sealed");

endmodule
`default_nettype wire

// [design/gcsd_cfg.svh]
// Constants for the control sub-command decoder: codes, status bit positions, timings.
// Assumes inclusion by the package and by the design modules through a plain include.
`ifndef GCSD_CFG_SVH
`define GCSD_CFG_SVH

// ==========================================================================
// Control command pair address and sub-command codes
// ==========================================================================
`define GCSD_CMD_CTRL_LO        8'h00
`define GCSD_CMD_CTRL_HI        8'h01
`define GCSD_SC_STATUS          16'h0000
`define GCSD_SC_DEV_TYPE        16'h0001
`define GCSD_SC_FW_REV          16'h0002
`define GCSD_SC_HW_REV          16'h0003
`define GCSD_SC_RESET_CNT       16'h0005
`define GCSD_SC_LAST_SC         16'h0007
`define GCSD_SC_CHEMISTRY_IDENTIFIER_QUERY         16'h0008
`define GCSD_SC_BOARD_CAL       16'h0009
`define GCSD_SC_CC_CAL          16'h000A
`define GCSD_SC_CC_STORE        16'h000B
`define GCSD_SC_FLASH_REV       16'h000C
`define GCSD_SC_ARM_DEEP        16'h0010
`define GCSD_SC_CHEM_CHK        16'h0017
`define GCSD_SC_CURRENT         16'h0018
`define GCSD_SC_SEAL            16'h0020
`define GCSD_SC_ALGO_START      16'h0021
`define GCSD_SC_CAL_TOGGLE      16'h002D
`define GCSD_SC_FULL_RESET      16'h0041
`define GCSD_SC_CAL_EXIT        16'h0080
`define GCSD_SC_CAL_ENTER       16'h0081
`define GCSD_SC_CAL_OFFSET      16'h0082
`define GCSD_LAST_SC_LIMIT      16'h0020

// ==========================================================================
// Status word, algorithm state and checksum result bit positions
// ==========================================================================
`define GCSD_ST_FAS             14
`define GCSD_ST_SS              13
`define GCSD_ST_CAL             12
`define GCSD_ST_CCA             11
`define GCSD_ST_BCA             10
`define GCSD_ST_CSV             9
`define GCSD_ST_DEEP            5
`define GCSD_ST_SLEEP           4
`define GCSD_ST_CPWR            3
`define GCSD_ST_RUPOFF          2
`define GCSD_ST_VOK             1
`define GCSD_ST_QEN             0
`define GCSD_ALGO_BIT           2
`define GCSD_CHK_MSB            15

// ==========================================================================
// Timing: wake clock stretch, least 6 ms
// ==========================================================================
`define GCSD_CLK_MHZ            125
`define GCSD_STRETCH_US         6000
`define GCSD_STRETCH_CYC        (`GCSD_STRETCH_US * `GCSD_CLK_MHZ)

`endif

// [design/gcsd_pkg.sv]
// Types for the control sub-command decoder.
// Assumes gcsd_cfg.svh sits beside it.
`include "gcsd_cfg.svh"

package gcsd_pkg;

    // One decoded sub-command strobe with its code
    typedef struct packed {
        logic        valid;
        logic [15:0] code;
    } gcsd_cmd_t;

    // Calibration engine states
    typedef enum logic [2:0] {
        GCSD_CAL_IDLE  = 3'b001,
        GCSD_CAL_BOARD = 3'b010,
        GCSD_CAL_CC    = 3'b100
    } gcsd_cal_st_t;

    // Measurement side inputs
    typedef struct packed {
        logic [15:0] current;
        logic [15:0] offset_meas;
        logic        meas_done;
        logic        volt_fit;
        logic        sleep_det;
        logic        const_pwr;
        logic        rup_off;
    } gcsd_meas_t;

endpackage

// [design/gcsd_chem_sum.sv]
// Chemistry checksum engine: sums static chemistry words from a small table.
// Assumes a start pulse on the same clock; table contents are parameters.
`timescale 1ns/10ps
`default_nettype none

module gcsd_chem_sum #(
    parameter int          N_WORDS = 8,
    parameter logic [15:0] SEED    = 16'h1234
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // Control
    input  wire logic        start_i,
    input  wire logic [14:0] ref_i,
    // Result
    output logic             done_o,
    output logic [15:0]      result_o
);
    import gcsd_pkg::*;

    typedef struct packed {
        logic        busy;
        logic [7:0]  idx;
        logic [15:0] acc;
        logic        done;
        logic [15:0] res;
    } gcsd_sum_st_t;

    gcsd_sum_st_t s_r;
    gcsd_sum_st_t s_nxt;
    logic [15:0]  table_w [N_WORDS];

    // ======================================================================
    // Static chemistry table, one word per entry
    // ======================================================================
    for (genvar g = 0; g < N_WORDS; g++) begin : g_tab
        assign table_w[g] = SEED + 16'(g * 16'h0101);
    end

    // ======================================================================
    // Sum, mask top bit, compare with reference
    // ======================================================================
    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        if (start_i && !s_r.busy) begin
            s_nxt.busy = 1'b1;
            s_nxt.idx  = 8'h00;
            s_nxt.acc  = 16'h0000;
        end else if (s_r.busy) begin
            if (s_r.idx == 8'(N_WORDS)) begin
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
                s_nxt.res  = {(s_r.acc[14:0] != ref_i), s_r.acc[14:0]};
            end else begin
                s_nxt.acc = s_r.acc + table_w[s_r.idx[$clog2(N_WORDS)-1:0]];
                s_nxt.idx = s_r.idx + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign done_o   = s_r.done;
    assign result_o = s_r.res;

    // Result flag must reflect the comparison
    property p_chk_flag;
        @(posedge clk_i) disable iff (!rstn_i)
        done_o |-> (result_o[15] == (result_o[14:0] != ref_i));
    endproperty
    a_chk_flag: assert property (p_chk_flag) else $error("checksum flag wrong");

    property p_chk_latency;
        @(posedge clk_i) disable iff (!rstn_i)
        (start_i && !s_r.busy) |-> ##[1:300] done_o;
    endproperty
    a_chk_latency: assert property (p_chk_latency) else $error("checksum never done");

endmodule
`default_nettype wire

// [verif/gcsd_host_model.sv]
// Host model: writes two-byte sub-commands to the control command pair.
// Assumes the bench calls send only after reset is released.
`timescale 1ns/10ps
`default_nettype none
`include "gcsd_cfg.svh"
module gcsd_host_model (
    // Clock
    input  wire logic       clk_i,
    // Byte writes
    output logic            wr_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o
);
    // ==========================================================
    // Idle bus
    initial begin
        wr_o = 1'b0;
        addr_o = 8'hff;
        wdata_o = 8'h00;
    end
    // Low byte, then high byte one edge later; high byte launches
    task automatic send(input logic [15:0] code);
        @(negedge clk_i);
        wr_o = 1'b1;
        addr_o = `GCSD_CMD_CTRL_LO;
        wdata_o = code[7:0];
        @(negedge clk_i);
        addr_o = `GCSD_CMD_CTRL_HI;
        wdata_o = code[15:8];
        @(negedge clk_i);
        wr_o = 1'b0;
        // Released lines show the inverse, never a stale value
        addr_o = ~addr_o;
        wdata_o = ~wdata_o;
    endtask
endmodule
`default_nettype wire

// [verif/gcsd_top_bench.sv]
// Bench for the control sub-command decoder: host model, checks, verdict.
// Assumes design files compiled first; one 125 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`include "gcsd_cfg.svh"
module gcsd_top_bench;
    import gcsd_pkg::*;
    // ==========================================================
    // Identity values, arbitrary
    localparam logic [15:0] ID_C [5] = '{16'h0001, 16'h0002, 16'h0003, 16'h0008, 16'h000C};
    localparam logic [15:0] ID_V [5] = '{16'h3C3C, 16'h0102, 16'h0003, 16'h0011, 16'h0007};
    localparam logic [15:0] CAL_C [4] = '{16'h0081, 16'h002D, 16'h002D, 16'h0080};
    localparam logic [3:0]  CAL_E = 4'b0101;
    logic        clk_i = 1'b0;
    logic        rstn_i;
    logic        wr, link_act, i2c, osc, str, drop, frst, kb;
    logic [7:0]  addr, wdata, algo;
    logic [15:0] ctrl, cco, bo, off;
    gcsd_meas_t  meas;
    int          miscompares = 0;
    int          tests_run = 0;
    int          nrst = 0;
    int          cyc = 0;
    int          ndrop = 0;
    // Short stretch keeps the run brief; reference matches the built-in chemistry table
    gcsd_top #(.STRETCH_CYC(20), .DEV_TYPE(ID_V[0]), .FW_REV(ID_V[1]), .HW_REV(ID_V[2]),
        .CHEMISTRY_IDENTIFIER_QUERY(ID_V[3]), .FLASH_REV(ID_V[4]), .CHEM_REF(15'h2DBC)) DUT (.clk_i(clk_i), .rstn_i(rstn_i),
        .wr_i(wr), .addr_i(addr), .wdata_i(wdata), .ctrl_pair_o(ctrl), .link_act_i(link_act),
        .link_is_i2c_i(i2c), .osc_run_o(osc), .stretch_o(str), .drop_msg_o(drop), .meas_i(meas),
        .full_reset_o(frst), .counter_offset_calibrate_o(cco), .board_offset_o(bo), .algo_state_o(algo));
    gcsd_host_model host (.clk_i(clk_i), .wr_o(wr), .addr_o(addr), .wdata_o(wdata));
    // ==========================================================
    // Clock, pulse counter, hang guard
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (frst === 1'b1) begin
            nrst++;
        end
        if (drop === 1'b1) begin
            ndrop++;
        end
        if (cyc == 6000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Send, then allow for the slowest answer
    task automatic cmd(input logic [15:0] c);
        host.send(c);
        repeat (16) @(negedge clk_i);
    endtask
    // Expected status: sealed, cal, board, counter, deep, volt, capacity
    function automatic logic [15:0] sw(input logic s, c, b, a, d, v, q);
        return {1'b0, s, s, c, a, b, 2'b00, 2'b00, d, 1'b0, meas.const_pwr, meas.rup_off, v, q};
    endfunction
    // Expected checksum answer: 16-bit sum of the table, top bit masked, match clears it
    function automatic logic [15:0] chem_exp();
        logic [15:0] acc;
        acc = 16'h0000;
        for (int g = 0; g < 8; g++) begin
            acc = acc + 16'h1234 + 16'(g * 16'h0101);
        end
        return {1'b0, acc[14:0]};
    endfunction
    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'he18b4470));
        rstn_i = 1'b0;
        link_act = 1'b0;
        i2c = 1'b1;
        meas = '0;
        meas.const_pwr = 1'($urandom);
        meas.rup_off = 1'($urandom);
        repeat (16) @(negedge clk_i);
        chk("pair_rst", ctrl, 16'h0000);
        chk("osc_rst", {15'h0, osc}, 16'h0001);
        rstn_i = 1'b1;
        cmd(16'h0000);
        chk("status", ctrl, sw(0, 0, 0, 0, 0, 0, 0));
        for (int i = 0; i < 5; i++) begin
            cmd(ID_C[i]);
            chk("ident", ctrl, ID_V[i]);
        end
        cmd(16'h0041);
        chk("full_reset", 16'(nrst), 16'h0001);
        cmd(16'h0005);
        chk("reset_cnt", ctrl, 16'h0001);
        cmd(16'h0003);
        cmd(16'h0007);
        chk("last_sc", ctrl, 16'h0003);
        meas.current = 16'($urandom);
        cmd(16'h0018);
        chk("current", ctrl, meas.current);
        // Board then counter calibration, busy until the measurement lands
        for (int k = 0; k < 2; k++) begin
            kb = k[0];
            off = 16'($urandom);
            cmd(kb ? 16'h000A : 16'h0009);
            cmd(16'h0000);
            chk("cal_busy", ctrl, sw(0, 0, ~kb, kb, 0, 0, 0));
            meas.offset_meas = off;
            meas.meas_done = 1'b1;
            @(negedge clk_i);
            meas.meas_done = 1'b0;
            cmd(16'h0000);
            chk("cal_idle", ctrl, sw(0, 0, 0, 0, 0, 0, 0));
            if (kb) begin
                cmd(16'h000B);
                chk("cc_off", cco, off);
            end else begin
                chk("board_off", bo, off);
            end
        end
        for (int i = 0; i < 4; i++) begin
            cmd(CAL_C[i]);
            cmd(16'h0000);
            chk("cal_mode", ctrl, sw(0, CAL_E[i], 0, 0, 0, 0, 0));
        end
        cmd(16'h0082);
        chk("offset_refused", ctrl, sw(0, 0, 0, 0, 0, 0, 0));
        cmd(16'h0081);
        cmd(16'h0082);
        chk("cal_offset", ctrl, off);
        cmd(16'h0080);
        meas.volt_fit = 1'b1;
        cmd(16'h0021);
        chk("algo_bit", {15'h0, algo[`GCSD_ALGO_BIT]}, 16'h0001);
        cmd(16'h0000);
        chk("algo_flags", ctrl, sw(0, 0, 0, 0, 0, 1, 1));
        meas.volt_fit = 1'b0;
        cmd(16'h0000);
        chk("vok_clear", ctrl, sw(0, 0, 0, 0, 0, 0, 1));
        // Deep sleep twice: two-wire wake stretches, single-wire wake drops a message
        for (int k = 0; k < 2; k++) begin
            kb = k[0];
            i2c = ~kb;
            cmd(16'h0010);
            cmd(16'h0000);
            chk("deep_arm", ctrl, sw(0, 0, 0, 0, 1, 0, 1));
            meas.sleep_det = 1'b1;
            repeat (4) @(negedge clk_i);
            chk("osc_stop", {15'h0, osc}, 16'h0000);
            link_act = 1'b1;
            repeat (6) @(negedge clk_i);
            chk("stretch", {15'h0, str}, {15'h0, ~kb});
            link_act = 1'b0;
            meas.sleep_det = 1'b0;
            repeat (40) @(negedge clk_i);
            chk("stretch_end", {15'h0, str}, 16'h0000);
            chk("osc_wake", {15'h0, osc}, 16'h0001);
            chk("drop", 16'(ndrop), 16'(k));
            cmd(16'h0000);
            chk("deep_clear", {15'h0, ctrl[`GCSD_ST_DEEP]}, 16'h0000);
        end
        // Sealed: only queries answer
        cmd(16'h0020);
        cmd(16'h0000);
        chk("sealed", ctrl, sw(1, 0, 0, 0, 0, 0, 1));
        cmd(16'h0001);
        cmd(16'h0005);
        chk("seal_refuse", ctrl, ID_V[0]);
        cmd(16'h0041);
        chk("seal_no_reset", 16'(nrst), 16'h0001);
        cmd(16'h0081);
        cmd(16'h0000);
        chk("seal_no_cal", ctrl, sw(1, 0, 0, 0, 0, 0, 1));
        // Checksum runs while sealed and marks the valid flag on a match
        cmd(16'h0017);
        chk("chem_sum", ctrl, chem_exp());
        cmd(16'h0000);
        chk("csv", ctrl, sw(1, 0, 0, 0, 0, 0, 1) | 16'h0200);
        report_and_stop();
    end
endmodule
`default_nettype wire
